/* acs_ccm_engine.sv */
// block-cipher coprocessor sequencer with ecb, cbc, cbc-mac, cfb, ofb and ctr
// assumes a same-clock byte register port and dma channels that follow the
// download and upload requests; ccm formatting and tag checks are software's
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"

module acs_ccm_engine #(
  parameter int ROUNDS = `ACS_CORE_ROUNDS
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  // register port
  input  wire acs_pkg::acs_bus_req_t bus_req,
  output logic [7:0]                rd_data,
  // dma triggers
  output logic                      dma_down_req,
  output logic                      dma_up_req,
  // block event
  output logic                      cipher_block_done_irq
);
  import acs_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_KEYIN, S_IVIN, S_DATAIN, S_CORE, S_KSTREAM, S_DATAOUT
  } acs_state_t;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic is_stream(input acs_mode_t m);
    return (m == ACS_MODE_CFB) || (m == ACS_MODE_OFB) || (m == ACS_MODE_CTR);
  endfunction

  function automatic logic [7:0] get_byte(input logic [127:0] v, input logic [3:0] i);
    return v[8'(8'd127 - {i, 3'h0}) -: 8];
  endfunction

  function automatic logic [127:0] put_byte(input logic [127:0] v, input logic [3:0] i,
                                            input logic [7:0] b);
    logic [127:0] r;
    r = v;
    r[8'(8'd127 - {i, 3'h0}) -: 8] = b;
    return r;
  endfunction

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  acs_state_t   state_reg,   state_next;
  logic [3:0]   cnt_reg,     cnt_next;
  logic [3:0]   ocnt_reg,    ocnt_next;
  logic [127:0] key_reg,     key_next;
  logic [127:0] iv_reg,      iv_next;
  logic [127:0] ctr_reg,     ctr_next;
  logic [127:0] buf_reg,     buf_next;
  logic [127:0] out_reg,     out_next;
  logic [127:0] fb_reg,      fb_next;
  logic [127:0] ks_reg,      ks_next;
  acs_mode_t    op_mode_reg, op_mode_next;
  logic         op_dec_reg,  op_dec_next;
  logic         core_go_reg, core_go_next;
  logic         irq_next;
  logic [2:0]   mode_reg;
  logic [1:0]   cmd_reg;
  logic         st_reg;
  logic [7:0]   din_last_reg;

  logic         core_done;
  logic [127:0] core_res;

  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  wire          ctl_wr    = bus_req.wr && (bus_req.addr == `ACS_CTL_ADDR);
  wire          din_wr    = bus_req.wr && (bus_req.addr == `ACS_DIN_ADDR);
  wire          dout_rd   = bus_req.rd && (bus_req.addr == `ACS_DOUT_ADDR);
  wire          start_req = ctl_wr && bus_req.wdata[`ACS_ST_BIT];
  wire acs_cmd_t  new_cmd = acs_cmd_t'(bus_req.wdata[`ACS_CMD_LSB +: 2]);
  wire acs_mode_t new_mode = acs_mode_t'(bus_req.wdata[`ACS_MODE_LSB +: 3]);
  wire          ready     = (state_reg == S_IDLE);
  wire          stream    = is_stream(op_mode_reg);
  wire          chain_enc = (op_mode_reg == ACS_MODE_MAC) ||
                            ((op_mode_reg == ACS_MODE_CBC) && !op_dec_reg);
  wire          cbc_dec   = (op_mode_reg == ACS_MODE_CBC) && op_dec_reg;
  wire [7:0]    ks_byte   = get_byte(ks_reg, cnt_reg);
  wire [7:0]    wbyte     = bus_req.wdata;

  // stream modes always run the core forward, on the iv for cfb/ofb and on the counter for ctr
  // ctr runs from its own counter, which a cfb/ofb tag step still advances by one
  wire [127:0]  ctr_din   = (op_mode_reg == ACS_MODE_CTR) ? ctr_reg : iv_reg;
  wire [127:0]  core_din  = stream ? ctr_din : (chain_enc ? buf_reg ^ iv_reg : buf_reg);
  wire          core_dec  = !stream && op_dec_reg && (op_mode_reg != ACS_MODE_MAC);

  wire [7:0]    status    = {1'b0, mode_reg, ready, cmd_reg, st_reg};
  wire [7:0]    rd_sel    = (bus_req.addr == `ACS_CTL_ADDR)  ? status :
                            (bus_req.addr == `ACS_DIN_ADDR)  ? din_last_reg :
                            (bus_req.addr == `ACS_DOUT_ADDR) ? get_byte(out_reg, ocnt_reg) :
                            `ACS_BYTE_RST;

  // -----------------------------------------------------------------
  // sequencing
  // -----------------------------------------------------------------
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    ocnt_next    = ocnt_reg;
    key_next     = key_reg;
    iv_next      = iv_reg;
    ctr_next     = ctr_reg;
    buf_next     = buf_reg;
    out_next     = out_reg;
    fb_next      = fb_reg;
    ks_next      = ks_reg;
    op_mode_next = op_mode_reg;
    op_dec_next  = op_dec_reg;
    core_go_next = 1'b0;
    irq_next     = 1'b0;
    unique case (state_reg)
      S_KEYIN, S_IVIN: begin
        if (din_wr) begin
          if (state_reg == S_KEYIN) begin
            key_next = put_byte(key_reg, cnt_reg, wbyte);
          end else begin
            iv_next  = put_byte(iv_reg, cnt_reg, wbyte);
            ctr_next = put_byte(ctr_reg, cnt_reg, wbyte);
          end
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == `ACS_LAST_BYTE) begin
            state_next = S_IDLE;
          end
        end
      end
      S_DATAIN: begin
        if (din_wr) begin
          buf_next = put_byte(buf_reg, cnt_reg, wbyte);
          out_next = put_byte(out_reg, cnt_reg, wbyte ^ ks_byte);
          // cfb feeds back the ciphertext side of each byte
          fb_next  = put_byte(fb_reg, cnt_reg, op_dec_reg ? wbyte : wbyte ^ ks_byte);
          cnt_next = cnt_reg + 4'h1;
          if (stream && (cnt_reg[1:0] == `ACS_PIECE_LAST)) begin
            state_next = S_DATAOUT;
          end else if (!stream && (cnt_reg == `ACS_LAST_BYTE)) begin
            state_next   = S_CORE;
            core_go_next = 1'b1;
          end
        end
      end
      S_CORE: begin
        if (core_done) begin
          out_next   = cbc_dec ? core_res ^ iv_reg : core_res;
          iv_next    = chain_enc ? core_res : (cbc_dec ? buf_reg : iv_reg);
          state_next = S_DATAOUT;
        end
      end
      S_KSTREAM: begin
        if (core_done) begin
          ks_next    = core_res;
          state_next = S_DATAIN;
        end
      end
      S_DATAOUT: begin
        if (dout_rd) begin
          ocnt_next = ocnt_reg + 4'h1;
          if (ocnt_reg == `ACS_LAST_BYTE) begin
            irq_next   = 1'b1;
            state_next = S_IDLE;
            // only the low word counts, so it wraps after 2^32 blocks
            if (stream) begin
              ctr_next = {ctr_reg[127:32], ctr_reg[31:0] + 32'h1};
            end
            unique case (op_mode_reg)
              ACS_MODE_CFB: iv_next = fb_reg;
              ACS_MODE_OFB: iv_next = ks_reg;
              default:      iv_next = iv_reg;
            endcase
          end else if (stream && (ocnt_reg[1:0] == `ACS_PIECE_LAST)) begin
            state_next = S_DATAIN;
          end
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    // key and iv loads abort whatever is running
    if (start_req && ((new_cmd == ACS_CMD_KEY) || (new_cmd == ACS_CMD_IV))) begin
      state_next   = (new_cmd == ACS_CMD_KEY) ? S_KEYIN : S_IVIN;
      op_mode_next = new_mode;
      cnt_next     = 4'h0;
      ocnt_next    = 4'h0;
      core_go_next = 1'b0;
    end else if (start_req && ready) begin
      // the counter state is kept, so a ctr step follows cfb/ofb directly
      op_mode_next = new_mode;
      op_dec_next  = (new_cmd == ACS_CMD_DEC);
      cnt_next     = 4'h0;
      ocnt_next    = 4'h0;
      if (is_stream(new_mode)) begin
        state_next   = S_KSTREAM;
        core_go_next = 1'b1;
      end else begin
        state_next = S_DATAIN;
      end
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= S_IDLE;
      cnt_reg     <= 4'h0;
      ocnt_reg    <= 4'h0;
      key_reg     <= `ACS_BLOCK_RST;
      iv_reg      <= `ACS_BLOCK_RST;
      ctr_reg     <= `ACS_BLOCK_RST;
      buf_reg     <= `ACS_BLOCK_RST;
      out_reg     <= `ACS_BLOCK_RST;
      fb_reg      <= `ACS_BLOCK_RST;
      ks_reg      <= `ACS_BLOCK_RST;
      op_mode_reg <= ACS_MODE_CBC;
      op_dec_reg  <= 1'b0;
      core_go_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      ocnt_reg    <= ocnt_next;
      key_reg     <= key_next;
      iv_reg      <= iv_next;
      ctr_reg     <= ctr_next;
      buf_reg     <= buf_next;
      out_reg     <= out_next;
      fb_reg      <= fb_next;
      ks_reg      <= ks_next;
      op_mode_reg <= op_mode_next;
      op_dec_reg  <= op_dec_next;
      core_go_reg <= core_go_next;
    end
  end

  // software view and outputs
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg              <= 3'h0;
      cmd_reg               <= 2'h0;
      st_reg                <= 1'b0;
      din_last_reg          <= `ACS_BYTE_RST;
      rd_data               <= `ACS_BYTE_RST;
      dma_down_req          <= 1'b0;
      dma_up_req            <= 1'b0;
      cipher_block_done_irq <= 1'b0;
    end else begin
      if (ctl_wr) begin
        mode_reg <= bus_req.wdata[`ACS_MODE_LSB +: 3];
        cmd_reg  <= bus_req.wdata[`ACS_CMD_LSB +: 2];
      end
      st_reg <= start_req;
      if (din_wr) begin
        din_last_reg <= wbyte;
      end
      rd_data               <= bus_req.rd ? rd_sel : `ACS_BYTE_RST;
      dma_down_req          <= (state_next == S_DATAIN) || (state_next == S_KEYIN) ||
                               (state_next == S_IVIN);
      dma_up_req            <= (state_next == S_DATAOUT);
      cipher_block_done_irq <= irq_next;
    end
  end

  // -----------------------------------------------------------------
  // cipher core
  // -----------------------------------------------------------------
  acs_block_cipher #(
    .ROUNDS (ROUNDS)
  ) u_core (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .start   (core_go_reg),
    .decrypt (core_dec),
    .key     (key_reg),
    .din     (core_din),
    .done    (core_done),
    .dout    (core_res)
  );

endmodule
`default_nettype wire

/* acs_map.svh */
// register offsets, field positions and reset values of the ccm sequencing engine
// assumes inclusion by bare name from the engine and the block cipher
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define ACS_DIN_ADDR     8'hb1
`define ACS_DOUT_ADDR    8'hb2
`define ACS_CTL_ADDR     8'hb3

// -----------------------------------------------------------------
// cipher_control_status fields
// -----------------------------------------------------------------
`define ACS_ST_BIT       0
`define ACS_CMD_LSB      1
`define ACS_RDY_BIT      3
`define ACS_MODE_LSB     4

// -----------------------------------------------------------------
// reset values and counts
// -----------------------------------------------------------------
`define ACS_BYTE_RST     8'h00
`define ACS_BLOCK_RST    128'h0
`define ACS_LAST_BYTE    4'hf
`define ACS_PIECE_LAST   2'h3
`define ACS_CORE_ROUNDS  10

`endif

/* acs_pkg.sv */
// types shared by the ccm sequencing engine and its cipher core
// includes no header; acs_map.svh serves the engine and the cipher core
package acs_pkg;

  typedef enum logic [2:0] {
    ACS_MODE_CBC = 3'h0,
    ACS_MODE_CFB = 3'h1,
    ACS_MODE_OFB = 3'h2,
    ACS_MODE_CTR = 3'h3,
    ACS_MODE_ECB = 3'h4,
    ACS_MODE_MAC = 3'h5,
    ACS_MODE_RS6 = 3'h6,
    ACS_MODE_RS7 = 3'h7
  } acs_mode_t;

  typedef enum logic [1:0] {
    ACS_CMD_ENC = 2'h0,
    ACS_CMD_DEC = 2'h1,
    ACS_CMD_KEY = 2'h2,
    ACS_CMD_IV  = 2'h3
  } acs_cmd_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acs_bus_req_t;

endpackage

/* acs_block_cipher.sv */
// iterative 128-bit keyed block permutation, one round per clock
// assumes key and data stay stable from start until done
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"

module acs_block_cipher #(
  parameter int ROUNDS = `ACS_CORE_ROUNDS
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  // request
  input  wire logic         start,
  input  wire logic         decrypt,
  input  wire logic [127:0] key,
  input  wire logic [127:0] din,
  // answer
  output logic              done,
  output logic [127:0]      dout
);
  import acs_pkg::*;

  // -----------------------------------------------------------------
  // feistel round pieces
  // -----------------------------------------------------------------
  // feistel keeps decryption exact without an inverse round function
  function automatic logic [63:0] mix(input logic [63:0] r, input logic [63:0] k);
    logic [63:0] s;
    s = r + k;
    return {s[50:0], s[63:51]} ^ (r & {r[62:0], r[63]});
  endfunction

  function automatic logic [63:0] round_key(input logic [127:0] k, input logic [7:0] idx);
    logic [255:0] d;
    d = {k, k} >> {idx[3:0], 3'h0};
    return d[63:0] ^ {56'h0, idx};
  endfunction

  logic [7:0]   rnd_reg;
  logic         busy_reg;
  logic         dec_reg;
  logic [127:0] st_reg;

  wire  [7:0]   last_rnd  = 8'(ROUNDS - 1);
  wire  [7:0]   key_idx   = dec_reg ? 8'(last_rnd - rnd_reg) : rnd_reg;
  wire  [63:0]  rk        = round_key(key, key_idx);
  wire  [127:0] enc_step  = {st_reg[63:0], st_reg[127:64] ^ mix(st_reg[63:0], rk)};
  wire  [127:0] dec_step  = {st_reg[63:0] ^ mix(st_reg[127:64], rk), st_reg[127:64]};

  // -----------------------------------------------------------------
  // round sequencing
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rnd_reg  <= 8'h00;
      busy_reg <= 1'b0;
      dec_reg  <= 1'b0;
      st_reg   <= `ACS_BLOCK_RST;
      done     <= 1'b0;
    end else begin
      done <= busy_reg && (rnd_reg == last_rnd);
      if (start) begin
        busy_reg <= 1'b1;
        dec_reg  <= decrypt;
        rnd_reg  <= 8'h00;
        st_reg   <= din;
      end else if (busy_reg) begin
        st_reg   <= dec_reg ? dec_step : enc_step;
        rnd_reg  <= rnd_reg + 8'h01;
        busy_reg <= (rnd_reg != last_rnd);
      end
    end
  end

  assign dout = st_reg;

endmodule
`default_nettype wire

/* acs_ccm_props.sv */
// port assertions for the ccm sequencing engine
// assumes acs_pkg is compiled first; bound to every acs_ccm_engine
`timescale 1ns/1ps
`default_nettype none

module acs_ccm_props #(
  parameter int ROUNDS = 10
) (
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  sys_rst,
  // register port
  input wire acs_pkg::acs_bus_req_t bus_req,
  input wire logic [7:0]            rd_data,
  // triggers and event
  input wire logic                  dma_down_req,
  input wire logic                  dma_up_req,
  input wire logic                  cipher_block_done_irq
);
  import acs_pkg::*;
  wire ctl_rd   = bus_req.rd && bus_req.addr == 8'hb3;
  wire start_wr = bus_req.wr && bus_req.addr == 8'hb3 && bus_req.wdata[0];

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // key or iv start: cmd field has its upper bit set
  sequence s_load_start;
    start_wr && bus_req.wdata[2];
  endsequence
  sequence s_fresh_status;
    ctl_rd && $past(start_wr);
  endsequence

  a_load_asks_data: assert property (s_load_start |=> dma_down_req)
    else $error("load start did not request data");
  a_st_reads_one: assert property (s_fresh_status |=> rd_data[0])
    else $error("start bit not seen after start");
  a_st_self_clear: assert property (ctl_rd && !$past(start_wr) |=> !rd_data[0])
    else $error("start bit did not clear");
  a_irq_one_pulse: assert property (cipher_block_done_irq |=> !cipher_block_done_irq)
    else $error("done pulse longer than one cycle");
  a_irq_after_read: assert property (cipher_block_done_irq |-> $past(bus_req.rd, 1)
    && $past(bus_req.addr, 1) == 8'hb2 && $past(dma_up_req, 1))
    else $error("done pulse without a final result read");
  a_irq_dma_idle: assert property (cipher_block_done_irq |-> !dma_up_req && !dma_down_req)
    else $error("transfer request still up at done");
  a_dma_exclusive: assert property (!(dma_down_req && dma_up_req))
    else $error("both transfer requests high");
  a_rd_idle_zero: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
    else $error("read data outside the answer cycle");
endmodule

bind acs_ccm_engine acs_ccm_props #(.ROUNDS(ROUNDS)) props_u (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .bus_req(bus_req),
  .rd_data(rd_data),
  .dma_down_req(dma_down_req),
  .dma_up_req(dma_up_req),
  .cipher_block_done_irq(cipher_block_done_irq)
);
`default_nettype wire

/* acs_dma_model.sv */
// dma channel pair feeding and draining the engine byte by byte
// assumes each command moves exactly 16 bytes in (and 16 out for data)
`timescale 1ns/1ps
`default_nettype none

module acs_dma_model (
  // clock
  input wire logic                sys_clk,
  // engine side
  input wire logic                dma_down_req,
  input wire logic                dma_up_req,
  input wire logic [7:0]          rd_data,
  // bench buffers
  input wire logic                stream,
  input wire logic [127:0]        in_blk,
  output logic [127:0]            out_blk,
  // bus side
  output acs_pkg::acs_bus_req_t   dma_req,
  output logic                    dma_act
);
  import acs_pkg::*;
  logic [3:0] in_ptr;
  logic [3:0] out_ptr;
  int         n;

  task automatic grab();
    out_blk[127 - 8 * out_ptr -: 8] = rd_data;
    out_ptr = out_ptr + 4'h1;
  endtask

  // one burst per trigger; pointers wrap since every block is whole
  initial begin
    dma_req = '0;
    dma_act = 1'b0;
    out_blk = '0;
    in_ptr = 4'h0;
    out_ptr = 4'h0;
    forever begin
      @(posedge sys_clk);
      n = stream ? 4 : 16;
      if (dma_down_req) begin
        dma_act <= 1'b1;
        repeat (n) begin
          dma_req.addr <= 8'hb1;
          dma_req.wr <= 1'b1;
          dma_req.wdata <= in_blk[127 - 8 * in_ptr -: 8];
          in_ptr = in_ptr + 4'h1;
          @(posedge sys_clk);
        end
        dma_req.wr <= 1'b0;
        dma_req.wdata <= ~dma_req.wdata;
        dma_act <= 1'b0;
        while (dma_down_req) @(posedge sys_clk);
      end else if (dma_up_req) begin
        dma_act <= 1'b1;
        dma_req.addr <= 8'hb2;
        dma_req.rd <= 1'b1;
        for (int i = 0; i < n; i++) begin
          @(posedge sys_clk);
          if (i > 0) grab();
        end
        dma_req.rd <= 1'b0;
        dma_act <= 1'b0;
        @(posedge sys_clk);
        grab();
        while (dma_up_req) @(posedge sys_clk);
      end
    end
  end
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the ccm sequencing engine
// assumes acs_pkg, the engine, its checker and the dma model are compiled
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import acs_pkg::*;
  logic          sys_clk = 1'b0;
  logic          sys_rst = 1'b1;
  acs_bus_req_t  tb_req;
  acs_bus_req_t  dma_req;
  logic          dma_act;
  wire acs_bus_req_t bus_req = dma_act ? dma_req : tb_req;
  logic [7:0]    rd_data;
  logic [7:0]    s;
  logic          dma_down_req;
  logic          dma_up_req;
  logic          irq;
  logic          stream;
  logic [127:0]  in_blk;
  logic [127:0]  out_blk;
  logic [127:0]  k1;
  logic [127:0]  k2;
  logic [127:0]  c;
  logic [127:0]  tag;
  logic [127:0]  tag_rx;
  logic [191:0]  cf;
  int            error_cnt = 0;
  int            checks_done = 0;
  // counter block: flag 05, nonce, 32-bit counter at its wrap point
  localparam logic [127:0] X = 128'h05a1b2c3d4e5f60718293a4bffffffff;
  localparam logic [127:0] P = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] T = 128'h0123456789abcdef0000000000000000;
  // auth_first_block: flag 1d (no adata, M=8, L-1=5), 13-byte nonce, length 16
  localparam logic [127:0] AUTH_FIRST = {8'h1d, 104'ha1b2c3d4e5f60718293a4b5c6d, 16'h0010};

  always #20 sys_clk = ~sys_clk;

  acs_ccm_engine #(.ROUNDS(2)) dut_u (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .dma_down_req(dma_down_req),
    .dma_up_req(dma_up_req),
    .cipher_block_done_irq(irq)
  );

  acs_dma_model dma_u (
    .sys_clk(sys_clk),
    .dma_down_req(dma_down_req),
    .dma_up_req(dma_up_req),
    .rd_data(rd_data),
    .stream(stream),
    .in_blk(in_blk),
    .out_blk(out_blk),
    .dma_req(dma_req),
    .dma_act(dma_act)
  );

  // ---------------------------------------------------------------
  // compares, bus cycles, commands
  // ---------------------------------------------------------------
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_blk(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    tb_req.addr <= a;
    tb_req.wdata <= d;
    tb_req.wr <= 1'b1;
    @(posedge sys_clk);
    tb_req.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    tb_req.addr <= a;
    tb_req.rd <= 1'b1;
    @(posedge sys_clk);
    tb_req.rd <= 1'b0;
    @(posedge sys_clk);
    d = rd_data;
  endtask

  // loads wait for the 16 bytes in, data waits for the done pulse
  task automatic run(input logic [1:0] cmd, input logic [2:0] mode, input logic [127:0] blk);
    logic [7:0] st;
    int         w;
    w = 0;
    in_blk = blk;
    stream = !cmd[1] && mode != 3'h0 && mode < 3'h4;
    bus_wr(8'hb3, {1'b0, mode, 1'b0, cmd, 1'b1});
    bus_rd(8'hb3, st);
    cmp_byte(st, {1'b0, mode, 1'b0, cmd, 1'b1});
    if (cmd[1]) begin
      while ((dma_act || dma_down_req) && w < 400) begin
        @(posedge sys_clk);
        w++;
      end
    end else begin
      while (irq !== 1'b1 && w < 400) begin
        @(posedge sys_clk);
        w++;
      end
      // the dma model takes the last result byte on this same edge
      @(posedge sys_clk);
    end
    if (w >= 400) error_cnt++;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    tb_req = '0;
    in_blk = '0;
    stream = 1'b0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    bus_rd(8'hb3, s);
    cmp_byte(s, 8'h08);
    bus_rd(8'hb2, s);
    cmp_byte(s, 8'h00);
    bus_rd(8'hc0, s);
    cmp_byte(s, 8'h00);
    $display("test reset done");
    run(2'h2, 3'h4, 128'hfedcba98765432100f1e2d3c4b5a6978);
    run(2'h3, 3'h4, 128'h0);
    run(2'h0, 3'h4, P);
    c = out_blk;
    run(2'h1, 3'h4, c);
    cmp_blk(out_blk, P);
    bus_rd(8'hb3, s);
    cmp_byte(s, 8'h4a);
    $display("test block round trip done");
    run(2'h3, 3'h3, X);
    run(2'h0, 3'h3, 128'h0);
    k1 = out_blk;
    run(2'h0, 3'h3, 128'h0);
    k2 = out_blk;
    run(2'h3, 3'h3, {X[127:32], 32'h0});
    run(2'h0, 3'h3, 128'h0);
    cmp_blk(out_blk, k2);
    run(2'h3, 3'h3, X);
    run(2'h0, 3'h3, P);
    c = out_blk;
    cmp_blk(c, P ^ k1);
    run(2'h3, 3'h3, X);
    run(2'h1, 3'h3, c);
    cmp_blk(out_blk, P);
    $display("test counter mode done");
    run(2'h3, 3'h2, X);
    run(2'h0, 3'h2, 128'h0);
    k1 = out_blk;
    run(2'h3, 3'h2, X);
    run(2'h0, 3'h2, T);
    cmp_blk(out_blk, T ^ k1);
    run(2'h3, 3'h1, X);
    run(2'h0, 3'h1, T);
    cmp_blk(out_blk, T ^ k1);
    $display("test tag encryption done");
    run(2'h3, 3'h5, 128'h0);
    run(2'h0, 3'h5, AUTH_FIRST);
    run(2'h0, 3'h0, P);
    tag = {out_blk[127:64], 64'h0};
    run(2'h3, 3'h2, X);
    run(2'h0, 3'h2, tag);
    cmp_blk({out_blk[127:64], 64'h0}, tag ^ {k1[127:64], 64'h0});
    cf[63:0] = out_blk[127:64];
    run(2'h0, 3'h3, P);
    cmp_blk(out_blk, P ^ k2);
    cf[191:64] = out_blk;
    run(2'h3, 3'h1, X);
    run(2'h1, 3'h1, {cf[63:0], 64'h0});
    tag_rx = {out_blk[127:64], 64'h0};
    cmp_blk(tag_rx, tag);
    run(2'h1, 3'h3, cf[191:64]);
    c = out_blk;
    cmp_blk(c, P);
    run(2'h3, 3'h5, 128'h0);
    run(2'h0, 3'h5, AUTH_FIRST);
    run(2'h0, 3'h0, c);
    cmp_blk({out_blk[127:64], 64'h0}, tag_rx);
    $display("test ccm round trip done");
    wrap_up();
  end
endmodule
`default_nettype wire
